// ### include/psr_pkg.sv
/*
 * psr_pkg: register map, field positions and bus codes of the
 * peripheral soft reset bank one block.
 * assumes: 32-bit register bus, byte addressed, one aligned word.
 */
package psr_pkg;

    ////////////////////////////////////////////////////////////////////
    // register map
    // system control base, decoded upstream of this block
    localparam logic [31:0] PSR_BASE_ADDR = 32'h400f_e000;
    // offset of peripheral_soft_reset_1
    localparam logic [11:0] PSR_SOFT_RESET_1_OFS = 12'h044;
    localparam logic [31:0] PSR_RESET_VALUE = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // field positions
    localparam int PSR_COMPARATOR_C_BIT = 26;
    localparam int PSR_COMPARATOR_B_BIT = 25;
    localparam int PSR_COMPARATOR_A_BIT = 24;
    localparam int PSR_GP_COUNTER_D_BIT = 19;
    localparam int PSR_GP_COUNTER_C_BIT = 18;
    localparam int PSR_GP_COUNTER_B_BIT = 17;
    localparam int PSR_GP_COUNTER_A_BIT = 16;
    localparam int PSR_TWOWIRE_B_BIT = 14;
    localparam int PSR_TWOWIRE_A_BIT = 12;
    localparam int PSR_ENCODER_B_BIT = 9;
    localparam int PSR_ENCODER_A_BIT = 8;
    localparam int PSR_SYNC_SERIAL_B_BIT = 5;
    localparam int PSR_SYNC_SERIAL_A_BIT = 4;
    localparam int PSR_ASYNC_SERIAL_C_BIT = 2;
    localparam int PSR_ASYNC_SERIAL_B_BIT = 1;
    localparam int PSR_ASYNC_SERIAL_A_BIT = 0;

    ////////////////////////////////////////////////////////////////////
    // group masks, built from the positions above
    localparam logic [31:0] PSR_ONE = 32'h0000_0001;
    localparam logic [31:0] PSR_COMPARATOR_MASK = (PSR_ONE << PSR_COMPARATOR_C_BIT)
        | (PSR_ONE << PSR_COMPARATOR_B_BIT) | (PSR_ONE << PSR_COMPARATOR_A_BIT);
    localparam logic [31:0] PSR_GP_COUNTER_MASK = (PSR_ONE << PSR_GP_COUNTER_D_BIT)
        | (PSR_ONE << PSR_GP_COUNTER_C_BIT) | (PSR_ONE << PSR_GP_COUNTER_B_BIT)
        | (PSR_ONE << PSR_GP_COUNTER_A_BIT);
    localparam logic [31:0] PSR_TWOWIRE_MASK = (PSR_ONE << PSR_TWOWIRE_B_BIT)
        | (PSR_ONE << PSR_TWOWIRE_A_BIT);
    localparam logic [31:0] PSR_ENCODER_MASK = (PSR_ONE << PSR_ENCODER_B_BIT)
        | (PSR_ONE << PSR_ENCODER_A_BIT);
    localparam logic [31:0] PSR_SYNC_SERIAL_MASK = (PSR_ONE << PSR_SYNC_SERIAL_B_BIT)
        | (PSR_ONE << PSR_SYNC_SERIAL_A_BIT);
    localparam logic [31:0] PSR_ASYNC_SERIAL_MASK = (PSR_ONE << PSR_ASYNC_SERIAL_C_BIT)
        | (PSR_ONE << PSR_ASYNC_SERIAL_B_BIT) | (PSR_ONE << PSR_ASYNC_SERIAL_A_BIT);
    // every bit that software may change; the rest read zero
    localparam logic [31:0] PSR_WRITABLE_MASK = PSR_COMPARATOR_MASK
        | PSR_GP_COUNTER_MASK | PSR_TWOWIRE_MASK | PSR_ENCODER_MASK
        | PSR_SYNC_SERIAL_MASK | PSR_ASYNC_SERIAL_MASK;

    ////////////////////////////////////////////////////////////////////
    // bus response codes
    localparam logic [1:0] PSR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PSR_RESP_SLVERR = 2'h2;

    // expand four byte strobes into a bit mask
    function automatic logic [31:0] psr_strobe_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : psr_strobe_mask

    // word address compare against the one register
    function automatic logic psr_addr_hit(input logic [11:0] addr);
        return addr[11:2] == PSR_SOFT_RESET_1_OFS[11:2];
    endfunction : psr_addr_hit

endpackage : psr_pkg

// ### design/psr_ctrl_reg.sv
/*
 * psr_ctrl_reg: storage of the reset control word with masked write.
 * assumes: write enable, data and masks come from logic on clk_i.
 */
module psr_ctrl_reg import psr_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [31:0] wdata_i,
    input wire logic [31:0] wmask_i,
    input wire logic [31:0] cap_i,
    // stored word
    output logic [31:0] ctrl_o
);

    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] en;

    ////////////////////////////////////////////////////////////////////
    // only present, writable, strobed bits take the new value
    always_comb begin
        en = wmask_i & cap_i & PSR_WRITABLE_MASK;
        ctrl_next = (ctrl_reg & ~en) | (wdata_i & en);
    end

    // reset control word, cleared by system reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= PSR_RESET_VALUE;
        end else if (wr_en_i) begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign ctrl_o = ctrl_reg;

endmodule : psr_ctrl_reg

// ### design/psr_soft_reset_bank.sv
/*
 * psr_soft_reset_bank: axi4-lite slave holding the soft reset word of
 * peripheral group one, driving one reset line per peripheral.
 * assumes: capability mask is a level from a register on clk_i.
 */
// Summary of operation
// - one 32-bit register at offset 0x044
// - system reset clears register to zero
// - capability mask gates every write bit
// - reserved bits read zero, ignore writes
// - comparator resets at bits 26..24
// - counter resets at bits 19..16
// - two-wire resets at bits 14, 12
// - encoder resets at bits 9, 8
// - sync serial resets at bits 5, 4
// - async serial resets at bits 2..0
module psr_soft_reset_bank import psr_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // write address channel
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [11:0] s_axi_awaddr_i,
    // write data channel
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    // write response channel
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    // read address channel
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [11:0] s_axi_araddr_i,
    // read data channel
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // capability mask of present units
    input wire logic [31:0] capability_mask_two_i,
    // peripheral reset lines, high holds the unit in reset
    output logic comparator_a_reset_o,
    output logic comparator_b_reset_o,
    output logic comparator_c_reset_o,
    output logic gp_counter_a_reset_o,
    output logic gp_counter_b_reset_o,
    output logic gp_counter_c_reset_o,
    output logic gp_counter_d_reset_o,
    output logic twowire_a_reset_o,
    output logic twowire_b_reset_o,
    output logic encoder_a_reset_o,
    output logic encoder_b_reset_o,
    output logic sync_serial_a_reset_o,
    output logic sync_serial_b_reset_o,
    output logic async_serial_a_reset_o,
    output logic async_serial_b_reset_o,
    output logic async_serial_c_reset_o
);

    logic awready_reg;
    logic wready_reg;
    logic aw_full_reg;
    logic w_full_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    logic ar_hs;
    logic r_hs;
    logic wr_go;
    logic wr_hit;
    logic [31:0] ctrl;

    ////////////////////////////////////////////////////////////////////
    // channel handshakes
    assign aw_hs = s_axi_awvalid_i && awready_reg;
    assign w_hs = s_axi_wvalid_i && wready_reg;
    assign b_hs = bvalid_reg && s_axi_bready_i;
    assign ar_hs = s_axi_arvalid_i && arready_reg;
    assign r_hs = rvalid_reg && s_axi_rready_i;
    // both halves held and no response pending: do the write
    assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_hit = wr_go && psr_addr_hit(aw_addr_reg);

    ////////////////////////////////////////////////////////////////////
    // write address capture, reopened after the response is taken
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            awready_reg <= 1'b1;
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
        end else begin
            if (aw_hs) begin
                awready_reg <= 1'b0;
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_i;
            end else if (wr_go) begin
                aw_full_reg <= 1'b0;
            end
            if (b_hs) begin
                awready_reg <= 1'b1;
            end
        end
    end

    // write data capture, independent of the address
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wready_reg <= 1'b1;
            w_full_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (w_hs) begin
                wready_reg <= 1'b0;
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata_i;
                wstrb_reg <= s_axi_wstrb_i;
            end else if (wr_go) begin
                w_full_reg <= 1'b0;
            end
            if (b_hs) begin
                wready_reg <= 1'b1;
            end
        end
    end

    // write response, error for any address but the register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= PSR_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? PSR_RESP_OKAY : PSR_RESP_SLVERR;
        end else if (b_hs) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read channel, one cycle from address to data, no side effects
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= PSR_RESP_OKAY;
        end else if (ar_hs) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            if (psr_addr_hit(s_axi_araddr_i)) begin
                rdata_reg <= ctrl & PSR_WRITABLE_MASK;
                rresp_reg <= PSR_RESP_OKAY;
            end else begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= PSR_RESP_SLVERR;
            end
        end else if (r_hs) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stored control word with capability gated write
    psr_ctrl_reg u_ctrl (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(wr_hit),
        .wdata_i(wdata_reg),
        .wmask_i(psr_strobe_mask(wstrb_reg)),
        .cap_i(capability_mask_two_i),
        .ctrl_o(ctrl)
    );

    ////////////////////////////////////////////////////////////////////
    // bus outputs straight from their flops
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;

    // reset lines follow the stored bits while they are set
    assign comparator_c_reset_o = ctrl[PSR_COMPARATOR_C_BIT];
    assign comparator_b_reset_o = ctrl[PSR_COMPARATOR_B_BIT];
    assign comparator_a_reset_o = ctrl[PSR_COMPARATOR_A_BIT];
    assign gp_counter_d_reset_o = ctrl[PSR_GP_COUNTER_D_BIT];
    assign gp_counter_c_reset_o = ctrl[PSR_GP_COUNTER_C_BIT];
    assign gp_counter_b_reset_o = ctrl[PSR_GP_COUNTER_B_BIT];
    assign gp_counter_a_reset_o = ctrl[PSR_GP_COUNTER_A_BIT];
    assign twowire_b_reset_o = ctrl[PSR_TWOWIRE_B_BIT];
    assign twowire_a_reset_o = ctrl[PSR_TWOWIRE_A_BIT];
    assign encoder_b_reset_o = ctrl[PSR_ENCODER_B_BIT];
    assign encoder_a_reset_o = ctrl[PSR_ENCODER_A_BIT];
    assign sync_serial_b_reset_o = ctrl[PSR_SYNC_SERIAL_B_BIT];
    assign sync_serial_a_reset_o = ctrl[PSR_SYNC_SERIAL_A_BIT];
    assign async_serial_c_reset_o = ctrl[PSR_ASYNC_SERIAL_C_BIT];
    assign async_serial_b_reset_o = ctrl[PSR_ASYNC_SERIAL_B_BIT];
    assign async_serial_a_reset_o = ctrl[PSR_ASYNC_SERIAL_A_BIT];

    ////////////////////////////////////////////////////////////////////
    // checking helpers: line vector and expected word after a write
    logic [31:0] line_vec;
    logic [31:0] exp_en;
    logic [31:0] exp_next;

    always_comb begin
        line_vec = 32'h0000_0000;
        line_vec[PSR_COMPARATOR_C_BIT] = comparator_c_reset_o;
        line_vec[PSR_COMPARATOR_B_BIT] = comparator_b_reset_o;
        line_vec[PSR_COMPARATOR_A_BIT] = comparator_a_reset_o;
        line_vec[PSR_GP_COUNTER_D_BIT] = gp_counter_d_reset_o;
        line_vec[PSR_GP_COUNTER_C_BIT] = gp_counter_c_reset_o;
        line_vec[PSR_GP_COUNTER_B_BIT] = gp_counter_b_reset_o;
        line_vec[PSR_GP_COUNTER_A_BIT] = gp_counter_a_reset_o;
        line_vec[PSR_TWOWIRE_B_BIT] = twowire_b_reset_o;
        line_vec[PSR_TWOWIRE_A_BIT] = twowire_a_reset_o;
        line_vec[PSR_ENCODER_B_BIT] = encoder_b_reset_o;
        line_vec[PSR_ENCODER_A_BIT] = encoder_a_reset_o;
        line_vec[PSR_SYNC_SERIAL_B_BIT] = sync_serial_b_reset_o;
        line_vec[PSR_SYNC_SERIAL_A_BIT] = sync_serial_a_reset_o;
        line_vec[PSR_ASYNC_SERIAL_C_BIT] = async_serial_c_reset_o;
        line_vec[PSR_ASYNC_SERIAL_B_BIT] = async_serial_b_reset_o;
        line_vec[PSR_ASYNC_SERIAL_A_BIT] = async_serial_a_reset_o;
        exp_en = psr_strobe_mask(wstrb_reg) & capability_mask_two_i;
        exp_next = (line_vec & ~exp_en) | (wdata_reg & exp_en);
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // both write halves held and no response pending
    sequence s_write_ready;
        aw_full_reg && w_full_reg && !s_axi_bvalid_o;
    endsequence

    sequence s_read_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence

    a_reset_clear: assert property (
        @(posedge clk_i) disable iff (1'b0)
        $rose(rst_n_i) |-> line_vec == PSR_RESET_VALUE && !s_axi_bvalid_o)
        else $error("reset lines not clear after reset");

    a_reserved_zero: assert property (
        s_axi_rvalid_o |-> (s_axi_rdata_o & ~PSR_WRITABLE_MASK) == 32'h0000_0000)
        else $error("reserved bit read nonzero");

    a_write_answer: assert property (
        s_write_ready |=> s_axi_bvalid_o ##0
        (s_axi_bresp_o == PSR_RESP_OKAY) == $past(psr_addr_hit(aw_addr_reg)))
        else $error("write response missing or wrong");

    a_resp_holds: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");

    a_capability_gate: assert property (
        s_write_ready |=> ((line_vec ^ $past(line_vec))
        & ~$past(capability_mask_two_i)) == 32'h0000_0000)
        else $error("absent unit bit changed");

    a_hold_stable: assert property (
        !wr_hit |=> $stable(line_vec))
        else $error("reset line changed without a write");

    a_read_value: assert property (
        s_read_taken ##0 psr_addr_hit(s_axi_araddr_i) |=> s_axi_rvalid_o
        && s_axi_rdata_o == $past(line_vec)
        && s_axi_rresp_o == PSR_RESP_OKAY)
        else $error("read data not the stored word");

    a_read_unmapped: assert property (
        s_read_taken ##0 !psr_addr_hit(s_axi_araddr_i) |=> s_axi_rvalid_o
        && s_axi_rdata_o == 32'h0000_0000 && s_axi_rresp_o == PSR_RESP_SLVERR)
        else $error("unmapped read not refused");

    a_comparator_write: assert property (
        wr_hit |=> ((line_vec ^ $past(exp_next)) & PSR_COMPARATOR_MASK) == 32'h0)
        else $error("comparator reset lines wrong after write");

    a_counter_write: assert property (
        wr_hit |=> ((line_vec ^ $past(exp_next)) & PSR_GP_COUNTER_MASK) == 32'h0)
        else $error("counter reset lines wrong after write");

    a_twowire_write: assert property (
        wr_hit |=> ((line_vec ^ $past(exp_next)) & PSR_TWOWIRE_MASK) == 32'h0)
        else $error("two-wire reset lines wrong after write");

    a_encoder_write: assert property (
        wr_hit |=> ((line_vec ^ $past(exp_next)) & PSR_ENCODER_MASK) == 32'h0)
        else $error("encoder reset lines wrong after write");

    a_sync_write: assert property (
        wr_hit |=> ((line_vec ^ $past(exp_next)) & PSR_SYNC_SERIAL_MASK) == 32'h0)
        else $error("sync serial reset lines wrong after write");

    a_async_write: assert property (
        wr_hit |=> ((line_vec ^ $past(exp_next)) & PSR_ASYNC_SERIAL_MASK) == 32'h0)
        else $error("async serial reset lines wrong after write");

endmodule : psr_soft_reset_bank

// ### verification/tb.sv
/*
 * tb: self-checking bench for psr_soft_reset_bank, driving its axi4-lite port.
 * assumes: psr_pkg and the design files are compiled first; 25 MHz clock.
 */
module tb import psr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // signals
    localparam logic [31:0] WR_MASK = 32'h070f_5337; // writable bit positions
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
    logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
    logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_i = 4'h0;
    logic [31:0] capability_mask_two_i = 32'hffff_ffff;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    wire logic [15:0] lines;
    wire logic [31:0] line_vec;
    int bad_count = 0;
    int tests_run = 0;

    // clock of 40 ns period
    always #20 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////
    // design under test
    psr_soft_reset_bank i_psr_soft_reset_bank (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
        .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o), .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_bvalid_o(s_axi_bvalid_o),
        .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
        .s_axi_araddr_i(s_axi_araddr_i), .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o), .capability_mask_two_i(capability_mask_two_i),
        .comparator_a_reset_o(lines[0]), .comparator_b_reset_o(lines[1]),
        .comparator_c_reset_o(lines[2]), .gp_counter_a_reset_o(lines[3]),
        .gp_counter_b_reset_o(lines[4]), .gp_counter_c_reset_o(lines[5]),
        .gp_counter_d_reset_o(lines[6]), .twowire_a_reset_o(lines[7]),
        .twowire_b_reset_o(lines[8]), .encoder_a_reset_o(lines[9]),
        .encoder_b_reset_o(lines[10]), .sync_serial_a_reset_o(lines[11]),
        .sync_serial_b_reset_o(lines[12]), .async_serial_a_reset_o(lines[13]),
        .async_serial_b_reset_o(lines[14]), .async_serial_c_reset_o(lines[15])
    );
    // reset lines placed at the bit positions they should follow
    assign line_vec = {5'h00, lines[2], lines[1], lines[0], 4'h0, lines[6], lines[5],
        lines[4], lines[3], 1'h0, lines[8], 1'h0, lines[7], 2'h0, lines[10], lines[9],
        2'h0, lines[12], lines[11], 1'h0, lines[15], lines[14], lines[13]};

    ////////////////////////////////////////////////////////////////////////
    // reporting
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s response %h expected %h", $time, what, got, exp);
        end
    endtask : chk_resp

    // waits for a settled level at the falling edge, bounded
    task automatic wait_high(ref logic sig, input string what);
        int n;
        n = 0;
        @(negedge clk_i);
        while (sig !== 1'h1) begin
            n++;
            if (n > 50) begin
                bad_count++;
                $display("[FAIL] %0t timeout waiting for %s", $time, what);
                end_of_test();
            end
            @(negedge clk_i);
        end
    endtask : wait_high

    ////////////////////////////////////////////////////////////////////////
    // bus master tasks
    task automatic axi_write(input logic [11:0] addr, input logic [31:0] data,
            input logic [3:0] strb, output logic [1:0] resp);
        bit aw_open;
        bit w_open;
        int n;
        aw_open = 1'b1;
        w_open = 1'b1;
        n = 0;
        @(posedge clk_i);
        s_axi_awaddr_i <= addr;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wdata_i <= data;
        s_axi_wstrb_i <= strb;
        s_axi_wvalid_i <= 1'h1;
        while (aw_open || w_open) begin
            @(negedge clk_i);
            n++;
            if (n > 50) begin
                bad_count++;
                $display("[FAIL] %0t timeout on write take", $time);
                end_of_test();
            end
            @(posedge clk_i);
            if (aw_open && s_axi_awready_o === 1'h1) begin
                s_axi_awvalid_i <= 1'h0;
                aw_open = 1'b0;
            end
            if (w_open && s_axi_wready_o === 1'h1) begin
                s_axi_wvalid_i <= 1'h0;
                w_open = 1'b0;
            end
        end
        wait_high(s_axi_bvalid_o, "write response");
        // late bready keeps the response standing one extra cycle
        @(posedge clk_i);
        s_axi_bready_i <= 1'h1;
        @(posedge clk_i);
        // response taken at the handshake edge
        resp = s_axi_bresp_o;
        s_axi_bready_i <= 1'h0;
    endtask : axi_write

    task automatic axi_read(input logic [11:0] addr, output logic [31:0] data,
            output logic [1:0] resp);
        @(posedge clk_i);
        s_axi_araddr_i <= addr;
        s_axi_arvalid_i <= 1'h1;
        wait_high(s_axi_arready_o, "read address ready");
        @(posedge clk_i);
        s_axi_arvalid_i <= 1'h0;
        wait_high(s_axi_rvalid_o, "read data");
        @(posedge clk_i);
        s_axi_rready_i <= 1'h1;
        @(posedge clk_i);
        // data and response taken at the handshake edge
        data = s_axi_rdata_o;
        resp = s_axi_rresp_o;
        s_axi_rready_i <= 1'h0;
    endtask : axi_read

    // reads the register back and compares it and the reset lines
    task automatic check_state(input logic [31:0] exp, input string what);
        logic [31:0] rd;
        logic [1:0] rsp;
        axi_read(12'h044, rd, rsp);
        chk_resp(rsp, PSR_RESP_OKAY, what);
        chk_word(rd, exp, what);
        chk_word(line_vec, exp, what);
    endtask : check_state

    // expected word after a masked write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
            input logic [3:0] strb, input logic [31:0] cap);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & cap & WR_MASK;
        return (old & ~m) | (data & m);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] model;
        logic [31:0] rd;
        logic [1:0] rsp;
        logic [3:0] strbs [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'h1;
        check_state(32'h0000_0000, "reset value");
        $display("test reset_value done");
        // walking one across every position, full capability
        for (int i = 0; i < 32; i++) begin
            axi_write(12'h044, 32'h0000_0001 << i, 4'hf, rsp);
            chk_resp(rsp, PSR_RESP_OKAY, "walk write");
            check_state((32'h0000_0001 << i) & WR_MASK, "walk");
        end
        $display("test walking_one done");
        // capability mask blocks absent units, then releases all
        model = 32'h0000_0000;
        capability_mask_two_i <= 32'h0505_a5a5;
        axi_write(12'h044, 32'hffff_ffff, 4'hf, rsp);
        model = merge(model, 32'hffff_ffff, 4'hf, 32'h0505_a5a5);
        check_state(model, "capability set");
        capability_mask_two_i <= 32'h0000_0000;
        axi_write(12'h044, 32'h0000_0000, 4'hf, rsp);
        check_state(model, "capability none");
        capability_mask_two_i <= 32'hffff_ffff;
        axi_write(12'h044, 32'h0000_0000, 4'hf, rsp);
        check_state(32'h0000_0000, "release all");
        $display("test capability done");
        // byte strobes one at a time, then an empty strobe
        model = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            axi_write(12'h044, 32'hffff_ffff, strbs[i], rsp);
            model = merge(model, 32'hffff_ffff, strbs[i], 32'hffff_ffff);
            check_state(model, "strobe");
        end
        axi_write(12'h044, 32'h0000_0000, 4'h0, rsp);
        chk_resp(rsp, PSR_RESP_OKAY, "empty strobe");
        check_state(model, "empty strobe");
        $display("test strobes done");
        // unmapped words neither write nor read the register
        axi_write(12'h048, 32'h0000_0000, 4'hf, rsp);
        chk_resp(rsp, PSR_RESP_SLVERR, "unmapped write");
        axi_read(12'h040, rd, rsp);
        chk_resp(rsp, PSR_RESP_SLVERR, "unmapped read");
        chk_word(rd, 32'h0000_0000, "unmapped read");
        check_state(model, "after unmapped");
        $display("test unmapped done");
        // software update keeping reserved bits as read
        axi_read(12'h044, rd, rsp);
        axi_write(12'h044, rd & 32'hfeff_ffcf, 4'hf, rsp);
        check_state(model & 32'hfeff_ffcf, "read modify write");
        $display("test read_modify_write done");
        // reset in mid run clears every line at once
        @(posedge clk_i);
        rst_n_i <= 1'h0;
        @(negedge clk_i);
        chk_word(line_vec, 32'h0000_0000, "during reset");
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'h1;
        check_state(32'h0000_0000, "after second reset");
        $display("test mid_reset done");
        end_of_test();
    end

endmodule : tb
